/* inc/fcis_map.svh */
/*
 * Register offsets, field positions and reset values of the flash
 * controller interrupt status block.
 * Assumes inclusion by bare name from design files.
 */
`ifndef FCIS_MAP_SVH
`define FCIS_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FCIS_OFF_RAW 12'h000C
`define FCIS_OFF_ENABLE 12'h0010
`define FCIS_OFF_PENDING 12'h0014

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define FCIS_BIT_ACCESS 0
`define FCIS_BIT_PROGRAM 1
`define FCIS_EVT_W 2
`define FCIS_EVT_RESET 2'h0
`define FCIS_WORD_ZERO 32'h0000_0000
`define FCIS_ADDR_W 12
`define FCIS_TRANS_NONSEQ 2'h2
`define FCIS_TRANS_SEQ 2'h3

`endif

/* inc/fcis_pkg.sv */
/*
 * Types shared by the flash controller interrupt status block.
 * Assumes fcis_map.svh is on the include path.
 */
`include "fcis_map.svh"

package fcis_pkg;
    typedef logic [`FCIS_EVT_W-1:0] fcis_evt_t;
    typedef logic [`FCIS_ADDR_W-1:0] fcis_addr_t;
endpackage

/* inc/fcis_reg_if.sv */
/*
 * Register access carrier between the bus slave and the event core.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/100ps

interface fcis_reg_if;
    logic wrEn;
    fcis_pkg::fcis_addr_t wrAddr;
    logic [31:0] wrData;
    fcis_pkg::fcis_evt_t rawSt;
    fcis_pkg::fcis_evt_t enableSt;
    fcis_pkg::fcis_evt_t pendSt;

    modport slave
    (
        output wrEn,
        output wrAddr,
        output wrData,
        input rawSt,
        input enableSt,
        input pendSt
    );
    modport core
    (
        input wrEn,
        input wrAddr,
        input wrData,
        output rawSt,
        output enableSt,
        output pendSt
    );
endinterface

/* src/fcis_ahb_slave.sv */
/*
 * AHB-Lite slave for the three event registers; zero wait states.
 * Assumes single word transfers; unmapped reads return zero, OKAY.
 */
`timescale 1ns/100ps
`include "fcis_map.svh"

module fcis_ahb_slave
(
    // System
    input wire logic clk,
    input wire logic srst,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    // Register side
    fcis_reg_if.slave regs
);
    logic wrPend_r;
    fcis_pkg::fcis_addr_t wrAddr_r;
    logic [31:0] rdData_r;
    logic valid;

    function automatic logic [31:0] readMux(input fcis_pkg::fcis_addr_t a,
        input fcis_pkg::fcis_evt_t raw, input fcis_pkg::fcis_evt_t en,
        input fcis_pkg::fcis_evt_t pend);
        readMux = `FCIS_WORD_ZERO;
        unique case (a)
            `FCIS_OFF_RAW: readMux[`FCIS_EVT_W-1:0] = raw;
            `FCIS_OFF_ENABLE: readMux[`FCIS_EVT_W-1:0] = en;
            `FCIS_OFF_PENDING: readMux[`FCIS_EVT_W-1:0] = pend;
            default: readMux = `FCIS_WORD_ZERO;
        endcase
    endfunction

    assign valid = hsel && hready &&
        (htrans == `FCIS_TRANS_NONSEQ || htrans == `FCIS_TRANS_SEQ);

    // ----------------------------------------------------------------
    // Address phase capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wrPend_r <= 1'b0;
            wrAddr_r <= '0;
        end
        else
        begin
            wrPend_r <= valid && hwrite;
            if (valid)
                wrAddr_r <= haddr[`FCIS_ADDR_W-1:0];
        end
    end

    // Read data sampled at address phase so it stands from a flop
    always_ff @(posedge clk)
    begin
        if (srst)
            rdData_r <= `FCIS_WORD_ZERO;
        else if (valid && !hwrite)
            rdData_r <= readMux(haddr[`FCIS_ADDR_W-1:0], regs.rawSt,
                regs.enableSt, regs.pendSt);
    end

    assign hrdata = rdData_r;
    assign regs.wrEn = wrPend_r;
    assign regs.wrAddr = wrAddr_r;
    assign regs.wrData = hwdata;
endmodule

/* src/fcis_event_core.sv */
/*
 * Raw status, enable and pending event logic of the flash controller.
 * Assumes event inputs are single-cycle pulses on the same clock.
 */
`timescale 1ns/100ps
`include "fcis_map.svh"

module fcis_event_core
(
    // System
    input wire logic clk,
    input wire logic srst,
    // Events
    input wire logic programDone,
    input wire logic accessViolation,
    // Register side
    fcis_reg_if.core regs
);
    fcis_pkg::fcis_evt_t raw_r;
    fcis_pkg::fcis_evt_t enable_r;
    fcis_pkg::fcis_evt_t clr;
    fcis_pkg::fcis_evt_t evt;

    assign evt = {programDone, accessViolation};
    // Only ones in the pending register clear; zeros are ignored
    assign clr = (regs.wrEn && regs.wrAddr == `FCIS_OFF_PENDING) ?
        regs.wrData[`FCIS_EVT_W-1:0] : `FCIS_EVT_RESET;

    // ----------------------------------------------------------------
    // Raw status: set wins over a clear in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            raw_r <= `FCIS_EVT_RESET;
        else
            raw_r <= (raw_r & ~clr) | evt;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            enable_r <= `FCIS_EVT_RESET;
        else if (regs.wrEn && regs.wrAddr == `FCIS_OFF_ENABLE)
            enable_r <= regs.wrData[`FCIS_EVT_W-1:0];
    end

    assign regs.rawSt = raw_r;
    assign regs.enableSt = enable_r;
    assign regs.pendSt = raw_r & enable_r;
endmodule

/* src/fcis_top.sv */
/*
 * Top of the flash controller interrupt status block: AHB-Lite
 * register access, event capture and one level interrupt output.
 * Assumes event pulses come from the flash sequencer on clk.
 */
`timescale 1ns/100ps
`include "fcis_map.svh"

// Overview of operation
// - Interrupt asserts for a source only when raw and enable are set.
// - Raw bit 1 reads 1 after a programming cycle finished, else 0.
// - Both word-write and erase completions set the program raw bit.
// - Raw bit 0 sets on an access forbidden by protection settings.
// - Enable bit 1 forwards a pending program completion.
// - Enable bit 0 forwards a pending protection violation.
// - A disabled source still records raw status but no interrupt.
// - Pending bit 1 is raw program bit and its enable.
// - Pending bit 0 is raw access bit and its enable.
// - Writing 1 to a pending bit clears that status bit.
// - Clearing pending bit 1 also clears raw program bit.
// - Clearing pending bit 0 also clears raw access bit.
module fcis_top
(
    // System
    input wire logic clk,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Flash sequencer events
    input wire logic writeDone,
    input wire logic eraseDone,
    input wire logic readDenied,
    input wire logic programDenied,
    // Interrupt
    output logic flashIrq
);
    fcis_reg_if regs();
    logic irq_r;
    logic hreadyout_r;
    logic hresp_r;

    logic programDone;
    logic accessViolation;

    assign programDone = writeDone | eraseDone;
    assign accessViolation = readDenied | programDenied;

    fcis_ahb_slave u_slave
    (
        .clk(clk),
        .srst(srst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .regs(regs.slave)
    );

    // Raw bits keep events whatever the enables
    // Ones clear raw and pending together
    fcis_event_core u_core
    (
        .clk(clk),
        .srst(srst),
        .programDone(programDone),
        .accessViolation(accessViolation),
        .regs(regs.core)
    );

    // ----------------------------------------------------------------
    // Interrupt output
    // ----------------------------------------------------------------
    // Registered from next-state so it tracks the pending bits exactly
    fcis_pkg::fcis_evt_t pendNxt;
    fcis_pkg::fcis_evt_t clrNow;
    logic enWr;
    assign clrNow = (regs.wrEn && regs.wrAddr == `FCIS_OFF_PENDING) ?
        regs.wrData[`FCIS_EVT_W-1:0] : `FCIS_EVT_RESET;
    assign enWr = regs.wrEn && regs.wrAddr == `FCIS_OFF_ENABLE;

    always_comb
    begin
        pendNxt = ((regs.rawSt & ~clrNow) |
            {programDone, accessViolation}) & regs.enableSt;
        if (enWr)
            pendNxt = ((regs.rawSt & ~clrNow) |
                {programDone, accessViolation}) &
                regs.wrData[`FCIS_EVT_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            irq_r <= 1'b0;
        else
            irq_r <= |pendNxt;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            hreadyout_r <= 1'b0;
        else
            hreadyout_r <= 1'b1;
    end

    // Only OKAY is ever answered, but the output still leaves a flop
    always_ff @(posedge clk)
    begin
        if (srst)
            hresp_r <= 1'b0;
        else
            hresp_r <= 1'b0;
    end

    assign flashIrq = irq_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_irq_follows;
        @(posedge clk) disable iff (srst)
        flashIrq == |(regs.rawSt & regs.enableSt);
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt differs from pending bits");

    property p_prog_sets;
        @(posedge clk) disable iff (srst)
        programDone |=> regs.rawSt[`FCIS_BIT_PROGRAM];
    endproperty
    a_prog_sets: assert property (p_prog_sets)
        else $error("program raw bit not set");

    property p_erase_sets;
        @(posedge clk) disable iff (srst)
        eraseDone |=> regs.rawSt[`FCIS_BIT_PROGRAM];
    endproperty
    a_erase_sets: assert property (p_erase_sets)
        else $error("erase did not set program bit");

    property p_acc_sets;
        @(posedge clk) disable iff (srst)
        accessViolation |=> regs.rawSt[`FCIS_BIT_ACCESS];
    endproperty
    a_acc_sets: assert property (p_acc_sets)
        else $error("access raw bit not set");

    property p_prog_irq;
        @(posedge clk) disable iff (srst)
        programDone && (enWr ? regs.wrData[`FCIS_BIT_PROGRAM] :
            regs.enableSt[`FCIS_BIT_PROGRAM]) |=> flashIrq;
    endproperty
    a_prog_irq: assert property (p_prog_irq)
        else $error("enabled program event gave no interrupt");

    property p_acc_irq;
        @(posedge clk) disable iff (srst)
        accessViolation && (enWr ? regs.wrData[`FCIS_BIT_ACCESS] :
            regs.enableSt[`FCIS_BIT_ACCESS]) |=> flashIrq;
    endproperty
    a_acc_irq: assert property (p_acc_irq)
        else $error("enabled access event gave no interrupt");

    property p_masked_quiet;
        @(posedge clk) disable iff (srst)
        regs.enableSt == 2'h0 |-> !flashIrq;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("interrupt while all disabled");

    property p_pend_prog;
        @(posedge clk) disable iff (srst)
        regs.pendSt[1] == (regs.rawSt[1] && regs.enableSt[1]);
    endproperty
    a_pend_prog: assert property (p_pend_prog)
        else $error("pending program bit wrong");

    property p_pend_acc;
        @(posedge clk) disable iff (srst)
        regs.pendSt[0] == (regs.rawSt[0] && regs.enableSt[0]);
    endproperty
    a_pend_acc: assert property (p_pend_acc)
        else $error("pending access bit wrong");

    property p_clear_prog;
        @(posedge clk) disable iff (srst)
        clrNow[1] && !programDone |=> !regs.rawSt[1];
    endproperty
    a_clear_prog: assert property (p_clear_prog)
        else $error("program bit not cleared");

    property p_clear_acc;
        @(posedge clk) disable iff (srst)
        clrNow[0] && !accessViolation |=> !regs.rawSt[0];
    endproperty
    a_clear_acc: assert property (p_clear_acc)
        else $error("access bit not cleared");

    property p_zero_keeps;
        @(posedge clk) disable iff (srst)
        regs.wrEn && regs.wrAddr == `FCIS_OFF_PENDING && !clrNow[1]
            && regs.rawSt[1] |=> regs.rawSt[1];
    endproperty
    a_zero_keeps: assert property (p_zero_keeps)
        else $error("write of zero cleared a bit");

    property p_set_wins;
        @(posedge clk) disable iff (srst)
        clrNow[1] && programDone |=> regs.rawSt[1];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a new event");

    property p_upper_zero;
        @(posedge clk) disable iff (srst)
        hrdata[31:2] == 30'h0000_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read bits not zero");

    property p_enable_off;
        @(posedge clk) disable iff (srst)
        enWr && regs.wrData[`FCIS_EVT_W-1:0] == `FCIS_EVT_RESET
            |=> !flashIrq;
    endproperty
    a_enable_off: assert property (p_enable_off)
        else $error("interrupt after all enables written off");

    property p_clear_all;
        @(posedge clk) disable iff (srst)
        &clrNow && !programDone && !accessViolation |=> !flashIrq;
    endproperty
    a_clear_all: assert property (p_clear_all)
        else $error("interrupt stayed after clearing both bits");

    property p_prog_cause;
        @(posedge clk) disable iff (srst)
        $rose(regs.rawSt[`FCIS_BIT_PROGRAM]) |-> $past(programDone);
    endproperty
    a_prog_cause: assert property (p_prog_cause)
        else $error("program raw bit set with no completion");

    property p_acc_cause;
        @(posedge clk) disable iff (srst)
        $rose(regs.rawSt[`FCIS_BIT_ACCESS]) |-> $past(accessViolation);
    endproperty
    a_acc_cause: assert property (p_acc_cause)
        else $error("access raw bit set with no violation");

    property p_prog_holds;
        @(posedge clk) disable iff (srst)
        regs.rawSt[`FCIS_BIT_PROGRAM] && !clrNow[`FCIS_BIT_PROGRAM]
            |=> regs.rawSt[`FCIS_BIT_PROGRAM];
    endproperty
    a_prog_holds: assert property (p_prog_holds)
        else $error("program raw bit lost without a clear");

    property p_acc_zero_keeps;
        @(posedge clk) disable iff (srst)
        regs.wrEn && regs.wrAddr == `FCIS_OFF_PENDING &&
            !clrNow[`FCIS_BIT_ACCESS] && regs.rawSt[`FCIS_BIT_ACCESS]
            |=> regs.rawSt[`FCIS_BIT_ACCESS];
    endproperty
    a_acc_zero_keeps: assert property (p_acc_zero_keeps)
        else $error("write of zero cleared the access bit");

    property p_acc_set_wins;
        @(posedge clk) disable iff (srst)
        clrNow[`FCIS_BIT_ACCESS] && accessViolation |=> regs.rawSt[0];
    endproperty
    a_acc_set_wins: assert property (p_acc_set_wins)
        else $error("clear beat a new access event");

    property p_enable_holds;
        @(posedge clk) disable iff (srst)
        !enWr |=> $stable(regs.enableSt);
    endproperty
    a_enable_holds: assert property (p_enable_holds)
        else $error("enable changed without a write");

    property p_ready_up;
        @(posedge clk) disable iff (srst)
        !$past(srst) |-> hreadyout;
    endproperty
    a_ready_up: assert property (p_ready_up)
        else $error("ready low outside reset");

    property p_okay;
        @(posedge clk) disable iff (srst)
        !hresp;
    endproperty
    a_okay: assert property (p_okay)
        else $error("response not OKAY");

    c_prog_irq: cover property (@(posedge clk) disable iff (srst)
        programDone && regs.enableSt[1] ##1 flashIrq);
    c_acc_irq: cover property (@(posedge clk) disable iff (srst)
        accessViolation && regs.enableSt[0] ##1 flashIrq);
    c_clear: cover property (@(posedge clk) disable iff (srst)
        flashIrq && clrNow != 2'h0 ##1 !flashIrq);
    c_collide: cover property (@(posedge clk) disable iff (srst)
        clrNow[1] && programDone);
    c_acc_collide: cover property (@(posedge clk) disable iff (srst)
        clrNow[0] && accessViolation);
endmodule

/* tb/fcis_flash_seq_model.sv */
/*
 * Model of the flash sequencer that feeds the event inputs.
 * Assumes the bench raises fire bits for one cycle on clk.
 */
`timescale 1ns/100ps

module fcis_flash_seq_model
(
    // System
    input wire logic clk,
    input wire logic srst,
    // Bench request: write, erase, read denied, program denied
    input wire logic [3:0] fire,
    // Event pulses
    output logic writeDone,
    output logic eraseDone,
    output logic readDenied,
    output logic programDenied
);
    // One registered cycle per request, as a real sequencer would give
    always_ff @(posedge clk)
    begin
        writeDone <= fire[0] & ~srst;
        eraseDone <= fire[1] & ~srst;
        readDenied <= fire[2] & ~srst;
        programDenied <= fire[3] & ~srst;
    end
endmodule

/* tb/flash_ctrl_interrupt_status_test.sv */
/*
 * Self-checking bench of the flash controller interrupt status block.
 * Assumes a zero wait AHB-Lite slave and the sequencer model.
 */
`timescale 1ns/100ps
`include "fcis_map.svh"

module flash_ctrl_interrupt_status_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [3:0] fire = 4'h0;
    logic writeDone, eraseDone, readDenied, programDenied, flashIrq;
    int errors = 0;
    int checked = 0;
    localparam logic [31:0] RAW = {20'h0_0000, `FCIS_OFF_RAW};
    localparam logic [31:0] ENA = {20'h0_0000, `FCIS_OFF_ENABLE};
    localparam logic [31:0] PND = {20'h0_0000, `FCIS_OFF_PENDING};

    initial
    begin
        forever #50 clk = ~clk;
    end

    fcis_top u_fcis_top
    (
        .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hsize(hsize), .hwrite(hwrite),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .writeDone(writeDone),
        .eraseDone(eraseDone), .readDenied(readDenied),
        .programDenied(programDenied), .flashIrq(flashIrq)
    );

    fcis_flash_seq_model u_fcis_flash_seq_model
    (
        .clk(clk), .srst(srst), .fire(fire), .writeDone(writeDone),
        .eraseDone(eraseDone), .readDenied(readDenied),
        .programDenied(programDenied)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Fire bits ride the address phase so the pulse meets the commit edge
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] d, input logic [3:0] f, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= `FCIS_TRANS_NONSEQ;
        hsize <= 3'h2;
        haddr <= a;
        hwrite <= w;
        fire <= f;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        fire <= 4'h0;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0000_0000);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, {30'h0, d[1:0]}, 4'h0, r);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0000_0000, 4'h0, r);
        chk(r, exp);
    endtask

    task automatic irq(input logic exp);
        #1;
        chk({31'h0, flashIrq}, {31'h0, exp});
    endtask

    task automatic ev(input logic [3:0] f);
        @(posedge clk);
        fire <= f;
        @(posedge clk);
        fire <= 4'h0;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        rd(RAW, 32'h0000_0000);
        rd(ENA, 32'h0000_0000);
        rd(PND, 32'h0000_0000);
        rd(32'h0000_0020, 32'h0000_0000);
        wr(RAW, 32'h0000_0003);
        rd(RAW, 32'h0000_0000);
        irq(1'b0);
    endtask

    task automatic t_masked();
        ev(4'h1);
        rd(RAW, 32'h0000_0002);
        rd(PND, 32'h0000_0000);
        irq(1'b0);
    endtask

    task automatic t_prog();
        wr(ENA, 32'h0000_0002);
        irq(1'b1);
        rd(PND, 32'h0000_0002);
        wr(PND, 32'h0000_0000);
        rd(RAW, 32'h0000_0002);
        wr(PND, 32'h0000_0002);
        irq(1'b0);
        rd(RAW, 32'h0000_0000);
        ev(4'h2);
        rd(RAW, 32'h0000_0002);
        irq(1'b1);
        wr(PND, 32'h0000_0002);
    endtask

    task automatic t_access();
        wr(ENA, 32'h0000_0001);
        ev(4'h4);
        rd(RAW, 32'h0000_0001);
        rd(PND, 32'h0000_0001);
        irq(1'b1);
        wr(ENA, 32'h0000_0000);
        irq(1'b0);
        rd(RAW, 32'h0000_0001);
        wr(ENA, 32'h0000_0001);
        wr(PND, 32'h0000_0002);
        rd(RAW, 32'h0000_0001);
        irq(1'b1);
        wr(PND, 32'h0000_0001);
        rd(RAW, 32'h0000_0000);
        ev(4'h8);
        rd(RAW, 32'h0000_0001);
        wr(PND, 32'h0000_0001);
        irq(1'b0);
    endtask

    task automatic t_collide();
        logic [31:0] r;
        wr(ENA, 32'h0000_0003);
        ev(4'h1);
        xfer(1'b1, PND, 32'h0000_0002, 4'h1, r);
        irq(1'b1);
        rd(RAW, 32'h0000_0002);
        wr(PND, 32'h0000_0003);
        rd(PND, 32'h0000_0000);
        ev(4'h4);
        xfer(1'b1, PND, 32'h0000_0001, 4'h4, r);
        rd(RAW, 32'h0000_0001);
        wr(PND, 32'h0000_0001);
    endtask

    task automatic t_midreset();
        ev(4'h5);
        irq(1'b1);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        chk({31'h0, hreadyout}, 32'h0000_0000);
        rd(RAW, 32'h0000_0000);
        rd(ENA, 32'h0000_0000);
        irq(1'b0);
    endtask

    task automatic wrap_up();
        if (errors == 0 && checked > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        chk({31'h0, hreadyout}, 32'h0000_0000);
        chk({31'h0, flashIrq}, 32'h0000_0000);
        chk(hrdata, 32'h0000_0000);
        t_reset();
        t_masked();
        t_prog();
        t_access();
        t_collide();
        t_midreset();
        wrap_up();
    end

    // Whole run is under two hundred cycles; this bounds any hang
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        wrap_up();
    end
endmodule
